//--- bmu_top.sv
// Summary of operation
// - xor carry with the complement of the chosen operand bit.
// - copy the chosen operand bit into carry.
// - copy the complement of the chosen operand bit into carry.
// - write carry into the chosen bit, other seven bits as read.
// - write the complement of carry into the chosen bit.
// - inverted operations take the bit number only from the immediate field.
// - set, clear, invert and stores read the byte, change one bit, write back.
// - reading the write-only direction register always returns ff.
// - data reads of input pins return the pin level.
// - data reads of output pins return the latch value.
// - direction 0 makes a pin input, 1 makes it drive the latch.
// - on an input pin the latch bit switches its pull-up on or off.
// - every operation works on one byte operand.
`timescale 1ns/10ps
`include "bmu_map.svh"
module bmu_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pullup_en,
  // status for the rest of the core
  output logic             carry_flag,
  output logic             busy
);
  import bmu_pkg::*;

  bmu_state_t st_reg;
  bmu_state_t st_next;
  bmu_port_if pbus ();

  logic       apb_acc;
  logic       apb_wr;
  logic       mapped;
  logic       ram_hit;
  logic [3:0] ram_idx;
  logic [7:0] opa_byte;
  logic       sel_bit;
  logic [7:0] mask;
  logic [2:0] start_bit;
  logic [31:0] rd_val;
  logic       start_ok;
  bmu_op_t    start_op;

  bmu_port u_port (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .bus       (pbus.port),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe),
    .pullup_en (pullup_en)
  );

  // apb decode; ram words sit in the low byte of each aligned word
  always_comb begin
    ram_hit = (paddr >= `BMU_OFF_RAM_LO) && (paddr <= `BMU_OFF_RAM_HI) && (paddr[1:0] == 2'b00);
    ram_idx = paddr[5:2];
    unique case (paddr)
      `BMU_OFF_CMD, `BMU_OFF_CARRY, `BMU_OFF_STATUS,
      `BMU_OFF_BITSRC, `BMU_OFF_DIR, `BMU_OFF_DATA: mapped = 1'b1;
      default: mapped = ram_hit;
    endcase
  end

  // apb read value; the direction register is write-only
  always_comb begin
    rd_val = 32'h0000_0000;
    if (ram_hit) begin
      rd_val[7:0] = st_reg.ram[ram_idx];
    end else begin
      unique case (paddr)
        `BMU_OFF_CMD: begin
          rd_val[`BMU_CMD_OP_MSB:`BMU_CMD_OP_LSB]   = st_reg.op;
          rd_val[`BMU_CMD_BIT_MSB:`BMU_CMD_BIT_LSB] = st_reg.bitno;
          rd_val[`BMU_CMD_ADR_MSB:`BMU_CMD_ADR_LSB] = st_reg.opa;
        end
        `BMU_OFF_CARRY:  rd_val[0] = st_reg.carry;
        `BMU_OFF_STATUS: begin
          rd_val[`BMU_STS_BUSY]    = (st_reg.fsm != BMU_ST_IDLE);
          rd_val[`BMU_STS_REFUSED] = st_reg.refused;
          rd_val[`BMU_STS_OPD_MSB:`BMU_STS_OPD_LSB] = st_reg.opd;
        end
        `BMU_OFF_BITSRC: rd_val[7:0] = st_reg.bitsrc;
        `BMU_OFF_DIR:    rd_val[7:0] = `BMU_DIR_READ;
        `BMU_OFF_DATA:   rd_val[7:0] = pbus.rd_data;
        default:         rd_val = 32'h0000_0000;
      endcase
    end
  end

  // byte seen at the operand address during the read phase
  always_comb begin
    if (st_reg.opa <= `BMU_OPA_RAM_TOP) begin
      opa_byte = st_reg.ram[st_reg.opa[3:0]];
    end else if (st_reg.opa == `BMU_OPA_DIR) begin
      opa_byte = `BMU_DIR_READ;
    end else begin
      opa_byte = pbus.rd_data;
    end
  end

  assign mask    = bmu_bit_mask(st_reg.bitno);
  assign sel_bit = bmu_bit_of(opa_byte, st_reg.bitno);

  // command decode at the write of the command register
  always_comb begin
    start_op = bmu_op_t'(pwdata[`BMU_CMD_OP_MSB:`BMU_CMD_OP_LSB]);
    unique case (start_op)
      BMU_OP_XOR_INV, BMU_OP_LOAD, BMU_OP_LOAD_INV, BMU_OP_STORE,
      BMU_OP_STORE_INV, BMU_OP_SET, BMU_OP_CLEAR, BMU_OP_INVERT: start_ok = 1'b1;
      default: start_ok = 1'b0;
    endcase
    // an operand address outside ram and the two port registers is refused
    if (pwdata[`BMU_CMD_ADR_MSB:`BMU_CMD_ADR_LSB] > `BMU_OPA_DATA) begin
      start_ok = 1'b0;
    end
    // only set, clear and invert may take the bit number from bitsrc
    unique case (start_op)
      BMU_OP_SET, BMU_OP_CLEAR, BMU_OP_INVERT: begin
        start_bit = pwdata[`BMU_CMD_BREG] ? st_reg.bitsrc[2:0]
                                          : pwdata[`BMU_CMD_BIT_MSB:`BMU_CMD_BIT_LSB];
      end
      default: start_bit = pwdata[`BMU_CMD_BIT_MSB:`BMU_CMD_BIT_LSB];
    endcase
  end

  assign apb_acc = psel & penable & pready;
  assign apb_wr  = apb_acc & pwrite;

  // sequencer, register file and apb write side
  always_comb begin
    st_next      = st_reg;
    pbus.wr_en   = 1'b0;
    pbus.wr_dir  = 1'b0;
    pbus.wr_data = 8'h00;

    unique case (st_reg.fsm)
      BMU_ST_IDLE: begin
        st_next.fsm = BMU_ST_IDLE;
      end
      BMU_ST_READ: begin
        // the whole byte is read, one bit is then worked on
        st_next.opd = opa_byte;
        st_next.fsm = BMU_ST_IDLE;
        unique case (st_reg.op)
          BMU_OP_XOR_INV:  st_next.carry = st_reg.carry ^ ~sel_bit;
          BMU_OP_LOAD:     st_next.carry = sel_bit;
          BMU_OP_LOAD_INV: st_next.carry = ~sel_bit;
          BMU_OP_STORE: begin
            st_next.wbyte = st_reg.carry ? (opa_byte | mask) : (opa_byte & ~mask);
            st_next.fsm   = BMU_ST_WRITE;
          end
          BMU_OP_STORE_INV: begin
            st_next.wbyte = st_reg.carry ? (opa_byte & ~mask) : (opa_byte | mask);
            st_next.fsm   = BMU_ST_WRITE;
          end
          BMU_OP_SET: begin
            st_next.wbyte = opa_byte | mask;
            st_next.fsm   = BMU_ST_WRITE;
          end
          BMU_OP_CLEAR: begin
            st_next.wbyte = opa_byte & ~mask;
            st_next.fsm   = BMU_ST_WRITE;
          end
          BMU_OP_INVERT: begin
            st_next.wbyte = opa_byte ^ mask;
            st_next.fsm   = BMU_ST_WRITE;
          end
          default: st_next.fsm = BMU_ST_IDLE;
        endcase
      end
      BMU_ST_WRITE: begin
        // full byte back to the same address; unchanged bits are what was read
        if (st_reg.opa <= `BMU_OPA_RAM_TOP) begin
          st_next.ram[st_reg.opa[3:0]] = st_reg.wbyte;
        end else begin
          pbus.wr_en   = 1'b1;
          pbus.wr_dir  = (st_reg.opa == `BMU_OPA_DIR);
          pbus.wr_data = st_reg.wbyte;
        end
        st_next.fsm = BMU_ST_IDLE;
      end
      default: st_next.fsm = BMU_ST_IDLE;
    endcase

    // read data is captured one cycle ahead so that prdata is a flop;
    // no transfer completes while an operation runs, which keeps the two
    // write paths into the port block apart
    st_next.rdy = psel & ~apb_acc & (st_reg.fsm == BMU_ST_IDLE);
    if (psel & ~apb_acc) begin
      st_next.prdata = rd_val;
    end

    if (apb_wr && mapped) begin
      if (ram_hit) begin
        st_next.ram[ram_idx] = pwdata[7:0];
      end else begin
        unique case (paddr)
          `BMU_OFF_CMD: begin
            if (start_ok) begin
              st_next.op    = start_op;
              st_next.bitno = start_bit;
              st_next.opa   = pwdata[`BMU_CMD_ADR_MSB:`BMU_CMD_ADR_LSB];
              st_next.fsm   = BMU_ST_READ;
            end else begin
              st_next.refused = 1'b1;
            end
          end
          `BMU_OFF_CARRY:  st_next.carry = pwdata[0];
          `BMU_OFF_STATUS: begin
            // write one to clear; a refusal in the same cycle cannot occur
            if (pwdata[`BMU_STS_REFUSED]) begin
              st_next.refused = 1'b0;
            end
          end
          `BMU_OFF_BITSRC: st_next.bitsrc = pwdata[7:0];
          `BMU_OFF_DIR: begin
            pbus.wr_en   = 1'b1;
            pbus.wr_dir  = 1'b1;
            pbus.wr_data = pwdata[7:0];
          end
          `BMU_OFF_DATA: begin
            pbus.wr_en   = 1'b1;
            pbus.wr_dir  = 1'b0;
            pbus.wr_data = pwdata[7:0];
          end
          default: st_next.refused = st_reg.refused;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg.fsm     <= BMU_ST_IDLE;
      st_reg.op      <= BMU_OP_NONE;
      st_reg.bitno   <= 3'h0;
      st_reg.opa     <= 5'h00;
      st_reg.wbyte   <= 8'h00;
      st_reg.opd     <= 8'h00;
      st_reg.carry   <= `BMU_CARRY_RST;
      st_reg.refused <= 1'b0;
      st_reg.bitsrc  <= 8'h00;
      st_reg.rdy     <= 1'b0;
      st_reg.prdata  <= 32'h0000_0000;
      st_reg.ram     <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // apb answer: zero-wait once the read data has been captured
  assign pready     = penable & st_reg.rdy;
  assign pslverr    = penable & st_reg.rdy & ~mapped;
  assign prdata     = st_reg.prdata;
  assign carry_flag = st_reg.carry;
  assign busy       = (st_reg.fsm != BMU_ST_IDLE);

endmodule // bmu_top

//--- bmu_map.svh
`ifndef BMU_MAP_SVH
`define BMU_MAP_SVH

// apb byte offsets
`define BMU_OFF_CMD      12'h000
`define BMU_OFF_CARRY    12'h004
`define BMU_OFF_STATUS   12'h008
`define BMU_OFF_BITSRC   12'h00c
`define BMU_OFF_DIR      12'h010
`define BMU_OFF_DATA     12'h014
`define BMU_OFF_RAM_LO   12'h040
`define BMU_OFF_RAM_HI   12'h07c

// command register fields
`define BMU_CMD_OP_LSB   0
`define BMU_CMD_OP_MSB   3
`define BMU_CMD_BIT_LSB  4
`define BMU_CMD_BIT_MSB  6
`define BMU_CMD_BREG     7
`define BMU_CMD_ADR_LSB  8
`define BMU_CMD_ADR_MSB  12

// status register fields
`define BMU_STS_BUSY     0
`define BMU_STS_REFUSED  1
`define BMU_STS_OPD_LSB  8
`define BMU_STS_OPD_MSB  15

// operand address space of the unit
`define BMU_OPA_RAM_TOP  5'h0f
`define BMU_OPA_DIR      5'h10
`define BMU_OPA_DATA     5'h11

// reset values and fixed read values
`define BMU_DIR_RST      8'h00
`define BMU_LATCH_RST    8'h00
`define BMU_DIR_READ     8'hff
`define BMU_CARRY_RST    1'b0

`endif

//--- bmu_pkg.sv
package bmu_pkg;

  // command codes written to the low nibble of the command register
  typedef enum logic [3:0] {
    BMU_OP_NONE      = 4'h0,
    BMU_OP_XOR_INV   = 4'h1,
    BMU_OP_LOAD      = 4'h2,
    BMU_OP_LOAD_INV  = 4'h3,
    BMU_OP_STORE     = 4'h4,
    BMU_OP_STORE_INV = 4'h5,
    BMU_OP_SET       = 4'h6,
    BMU_OP_CLEAR     = 4'h7,
    BMU_OP_INVERT    = 4'h8
  } bmu_op_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    BMU_ST_IDLE  = 3'b001,
    BMU_ST_READ  = 3'b010,
    BMU_ST_WRITE = 3'b100
  } bmu_fsm_t;

  // whole state of the datapath top
  typedef struct packed {
    bmu_fsm_t          fsm;
    bmu_op_t           op;
    logic [2:0]        bitno;
    logic [4:0]        opa;
    logic [7:0]        wbyte;
    logic [7:0]        opd;
    logic              carry;
    logic              refused;
    logic [7:0]        bitsrc;
    logic              rdy;
    logic [31:0]       prdata;
    logic [15:0][7:0]  ram;
  } bmu_state_t;

  // whole state of the port block
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
  } bmu_port_state_t;

  // one-hot mask for a bit number
  function automatic logic [7:0] bmu_bit_mask(input logic [2:0] n);
    bmu_bit_mask = 8'h01 << n;
  endfunction

  // selected bit of a byte
  function automatic logic bmu_bit_of(input logic [7:0] b, input logic [2:0] n);
    bmu_bit_of = |(b & bmu_bit_mask(n));
  endfunction

endpackage

//--- bmu_port_if.sv
`timescale 1ns/10ps
// carrier between the sequencer and the port block
interface bmu_port_if;
  logic       wr_en;
  logic       wr_dir;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  modport cpu  (output wr_en, output wr_dir, output wr_data, input rd_data);
  modport port (input wr_en, input wr_dir, input wr_data, output rd_data);
endinterface

//--- bmu_port.sv
`timescale 1ns/10ps
module bmu_port (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // internal bus side
  bmu_port_if.port        bus,
  // pins
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pullup_en
);
  import bmu_pkg::*;

  bmu_port_state_t st_reg;
  bmu_port_state_t st_next;

  // next state: the direction register and the latch take whole bytes
  always_comb begin
    st_next = st_reg;
    if (bus.wr_en) begin
      if (bus.wr_dir) begin
        st_next.dir = bus.wr_data;
      end else begin
        st_next.latch = bus.wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg.dir   <= `BMU_DIR_RST;
      st_reg.latch <= `BMU_LATCH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // inputs show the pin, outputs show the latch
  assign bus.rd_data = (pin_in & ~st_reg.dir) | (st_reg.latch & st_reg.dir);

  // direction 1 drives the latch onto the pin, 0 leaves it an input
  assign pin_out   = st_reg.latch;
  assign pin_oe    = st_reg.dir;
  // on an input the latch bit only switches the pull-up
  assign pullup_en = st_reg.latch & ~st_reg.dir;

endmodule // bmu_port

//--- bmu_pins_model.sv
`timescale 1ns/10ps
module bmu_pins_model (
  // clock
  input  wire logic       ref_clk,
  // device pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // outside drivers set by the bench
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // level seen by the device
  output logic      [7:0] pin_in
);
  logic flip = 1'b0;
  // an undriven pin without pull-up wanders, so a stale level never passes
  always @(posedge ref_clk) flip <= ~flip;
  // device drive wins, then an outside driver, then the pull-up
  assign pin_in = (pin_oe & pin_out)
                | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_en | {4{flip, ~flip}}));
endmodule // bmu_pins_model

//--- bmu_top_props.sv
`timescale 1ns/10ps
module bmu_top_props (
  // clock and reset
  input logic        ref_clk,
  input logic        sys_rst,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // pins and status
  input logic [7:0]  pin_in,
  input logic [7:0]  pin_out,
  input logic [7:0]  pin_oe,
  input logic [7:0]  pullup_en,
  input logic        carry_flag,
  input logic        busy
);
  logic acc;
  // transfer completing at this edge
  assign acc = psel & penable & pready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // accepted command with op code in lo..hi and operand in range
  sequence s_cmd(lo, hi);
    acc && pwrite && paddr == 12'h000 && pwdata[3:0] >= lo && pwdata[3:0] <= hi
      && pwdata[12:8] <= 5'h11;
  endsequence
  sequence s_rmw;
    busy [*2] ##1 !busy;
  endsequence
  a_flag_len: assert property (s_cmd(4'h1, 4'h3) |=> busy ##1 !busy)
    else $error("flag op busy length wrong");
  a_flag_nowr: assert property (s_cmd(4'h1, 4'h3) |=> ($stable(pin_out) && $stable(pin_oe)) [*3])
    else $error("flag op changed a port register");
  a_rmw_len: assert property (s_cmd(4'h4, 4'h8) |=> s_rmw)
    else $error("rmw op not read then write");
  a_dir_clear: assert property (acc && pwrite && paddr == 12'h000 && pwdata[12:0] ==? 13'h1007
    |=> ##2 pin_oe == ~(8'h01 << $past(pwdata[6:4], 3)))
    else $error("direction clear did not write ff with one bit cleared");
  a_dir_ff: assert property (acc && !pwrite && paddr == 12'h010 |-> prdata[7:0] == 8'hff)
    else $error("direction read not ff");
  a_data_out: assert property (acc && !pwrite && paddr == 12'h014
    |-> (prdata[7:0] & pin_oe) == (pin_out & pin_oe))
    else $error("output pin read not latch");
  a_pullup_map: assert property (pullup_en == (pin_out & ~pin_oe))
    else $error("pull-up not latch of input pins");
  a_busy_stall: assert property (busy |-> !pready)
    else $error("bus answered during an operation");
  a_ready_enable: assert property (pready || pslverr |-> penable && psel)
    else $error("ready outside access phase");
endmodule // bmu_top_props
bind bmu_top bmu_top_props bmu_top_props_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pullup_en(pullup_en), .carry_flag(carry_flag), .busy(busy)
);

//--- tb_bit_manipulation_rmw_unit.sv
`timescale 1ns/10ps
module tb_bit_manipulation_rmw_unit;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, carry_flag, busy, er;
  logic [7:0]  pin_in, pin_out, pin_oe, pullup_en;
  logic [7:0]  ext_en = 8'hc1;
  logic [7:0]  ext_val = 8'h41;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  // op, bit source and bit, carry in and out, byte after; operand 5a, bit source 2
  logic [19:0] rows [16] = '{20'h1935a, 20'h1025a, 20'h2415a, 20'h2025a,
    20'h3e05a, 20'h4035b, 20'h43052, 20'h59358, 20'h570da, 20'h6005b,
    20'h6f35e, 20'h71058, 20'h7631a, 20'h8005b, 20'h873da, 20'h8c05e};

  bmu_top bmu_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .carry_flag(carry_flag), .busy(busy)
  );
  bmu_pins_model bmu_pins_model_i (
    .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  // 200 mhz clock
  always #2.5 ref_clk = ~ref_clk;
  // watchdog; the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // reset for three edges, then the pins, carry_flag and busy must be clear
  task automatic rst();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk_pin("reset", 8'h00, pin_out | pin_oe | pullup_en | {6'h0, carry_flag, busy});
  endtask
  // one apb transfer; pready and read data are taken at the rising edge that completes it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial begin
    rst();
    apb(1'b1, 12'h00c, 32'h2);
    // every op code on a ram byte
    foreach (rows[i]) begin
      apb(1'b1, 12'h04c, 32'h5a);
      apb(1'b1, 12'h004, {31'h0, rows[i][9]});
      apb(1'b1, 12'h000, {19'h0, 5'h03, rows[i][15:12], rows[i][19:16]});
      apb(1'b0, 12'h004, 32'h0);
      chk_bus("carry", {31'h0, rows[i][8]}, rd);
      chk_pin("carry_flag", {7'h0, rows[i][8]}, {7'h0, carry_flag});
      apb(1'b0, 12'h04c, 32'h0);
      chk_bus("byte", {24'h0, rows[i][7:0]}, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk_bus("status", 32'h5a00, rd);
    end
    // refused commands: op code 9, then operand beyond the port
    apb(1'b1, 12'h000, 32'h0309);
    apb(1'b0, 12'h008, 32'h0);
    chk_bus("refused", 32'h2, rd & 32'h3);
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk_bus("refused", 32'h0, rd & 32'h3);
    apb(1'b1, 12'h000, 32'h1206);
    apb(1'b0, 12'h008, 32'h0);
    chk_bus("refused", 32'h2, rd & 32'h3);
    apb(1'b0, 12'h020, 32'h0);
    chk_bus("unmapped", 32'h1, {rd[30:0], er});
    // second reset mid-run, then set bit 0 of the data latch with two input pins
    rst();
    apb(1'b0, 12'h010, 32'h0);
    chk_bus("dir", 32'hff, rd);
    apb(1'b1, 12'h010, 32'h3f);
    apb(1'b1, 12'h014, 32'h80);
    apb(1'b0, 12'h014, 32'h0);
    chk_bus("data", 32'h40, rd);
    chk_pin("pullup", 8'h80, pullup_en);
    apb(1'b1, 12'h000, 32'h1106);
    apb(1'b0, 12'h014, 32'h0);
    chk_bus("data", 32'h41, rd);
    chk_pin("pullup", 8'h40, pullup_en);
    chk_pin("pins", 8'h41, pin_out);
    // clear bit 0 of the direction register: its read of ff turns inputs to outputs
    apb(1'b1, 12'h014, 32'h80);
    apb(1'b1, 12'h000, 32'h1007);
    apb(1'b0, 12'h010, 32'h0);
    chk_bus("dir", 32'hff, rd);
    chk_pin("oe", 8'hfe, pin_oe);
    chk_pin("pullup", 8'h00, pullup_en);
    apb(1'b0, 12'h014, 32'h0);
    chk_bus("data", 32'h81, rd);
    stop_test();
  end
endmodule // tb_bit_manipulation_rmw_unit
